// File: hw/sbc_irq_pkg.sv
// Constants, field layout and codes shared by the interrupt encoder files
package sbc_irq_pkg;

    // ---------------------------------------------------------------
    // Control word layout
    // ---------------------------------------------------------------
    localparam int          WORD_W       = 16;
    localparam int          MS_LSB       = 0;
    localparam int          CS_LSB       = 3;
    localparam logic [2:0]  MS_INVALID   = 3'h0;
    localparam logic [2:0]  MS_READ_ONLY = 3'h7;
    localparam logic [2:0]  CS_WAKE      = 3'h0;
    localparam logic [2:0]  CS_FAIL      = 3'h1;
    localparam logic [2:0]  CS_LINK      = 3'h2;

    // ---------------------------------------------------------------
    // Wake event register bits
    // ---------------------------------------------------------------
    localparam int CAN_WAKE_FLAG_BIT      = 6;
    localparam int WK_LIN_BIT      = 7;
    localparam int WK_FALL_BIT     = 8;
    localparam int WK_RISE_BIT     = 9;
    localparam int WK_PERIODIC_BIT = 10;
    localparam int WK_SUMMARY_BIT  = 11;

    // ---------------------------------------------------------------
    // Chip failure register bits
    // ---------------------------------------------------------------
    localparam int FL_HEAT_BIT  = 6;
    localparam int FL_CANOT_BIT = 7;
    localparam int FL_OT2_BIT   = 8;
    localparam int FL_UV3_BIT   = 9;
    localparam int FL_SPI_BIT   = 10;
    localparam int FL_RST_BIT   = 11;
    localparam int FL_WD_BIT    = 12;
    localparam int FL_UV2_BIT   = 13;
    localparam int FL_OC3_BIT   = 14;

    // ---------------------------------------------------------------
    // Link failure register bits
    // ---------------------------------------------------------------
    localparam int LK_CAN_LSB = 6;
    localparam int LK_BUS_BIT = 8;
    localparam int LK_LIN_LSB = 9;

    // ---------------------------------------------------------------
    // Masks and reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] WAKE_EN_MASK = 16'h03c0;
    localparam logic [15:0] FAIL_EN_MASK = 16'h7fc0;
    localparam logic [15:0] LINK_EN_MASK = 16'h0340;
    localparam logic [15:0] WAKE_EN_RST  = WAKE_EN_MASK;
    localparam logic [15:0] FAIL_EN_RST  = FAIL_EN_MASK;
    localparam logic [15:0] LINK_EN_RST  = LINK_EN_MASK;
    localparam logic [15:0] STATUS_RST   = 16'h0000;

    // ---------------------------------------------------------------
    // Synchronised input vector
    // ---------------------------------------------------------------
    localparam int SYNC_W     = 12;
    localparam int SY_PIN     = 0;
    localparam int SY_HEAT    = 1;
    localparam int SY_CANOT   = 2;
    localparam int SY_OT2     = 3;
    localparam int SY_UV3     = 4;
    localparam int SY_UV2     = 5;
    localparam int SY_OC3     = 6;
    localparam int SY_BUS     = 7;
    localparam int SY_CAN_LSB = 8;
    localparam int SY_LIN_LSB = 10;

    typedef enum logic [1:0] {
        FAULT_NONE     = 2'h0,
        FAULT_TXD_LOW  = 2'h1,
        FAULT_RXD_HIGH = 2'h2,
        FAULT_TXD_RXD  = 2'h3
    } xcvr_fault_t;

endpackage

// File: hw/level_sync_if.sv
// Carrier between an asynchronous level group and its synchroniser
`timescale 1ns/10ps
interface level_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// File: hw/level_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
module level_sync #(
    parameter int W = 1
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    level_sync_if.sync      lvl
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] clean_reg;
    logic [W-1:0] clean_next;

    // First stage is read only by the second stage
    always_comb begin
        meta_next  = lvl.raw;
        clean_next = meta_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            meta_reg  <= '0;
            clean_reg <= '0;
        end else begin
            meta_reg  <= meta_next;
            clean_reg <= clean_next;
        end
    end

    assign lvl.clean = clean_reg;
endmodule

// File: hw/sbc_interrupt_event_encoder.sv
// Interrupt enables, event status and interrupt pin of the basis chip
//
// What this block does
// - Interrupt pin held until matching register read
// - All enable bits are one after reset
// - Writing zero selects the opposite state
// - Wake register reports CAN wake events
// - Wake register reports LIN wake events
// - Wake pin edge select and edge report
// - Summary bit flags non-zero failure status registers
// - Main regulator heat warning enable and status
// - CAN and second regulator overheat pairs
// - Third supply undervoltage interrupts on both edges
// - Corrupted host frame enable and status
// - Reset info only in development mode
// - Watchdog setting error enable and status
// - Second supply undervoltage enable and status
// - Third supply overcurrent enable and status
// - CAN fault enable with 2-bit code
// - CAN bus failure enable and status
// - LIN fault enable with 2-bit code
// - Fault codes none, txd, rxd, txd-rxd
// - Bad frame sets fail bit, maybe interrupts
// - Register picked by 3-bit select field
`timescale 1ns/10ps
module sbc_interrupt_event_encoder (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        frame_done,
    input  wire logic [15:0] frame_word,
    input  wire logic        frame_len_error,
    input  wire logic        mode_refused,
    input  wire logic        sw_dev_mode,
    input  wire logic        can_wake_evt,
    input  wire logic        lin_wake_evt,
    input  wire logic        periodic_wake_evt,
    input  wire logic        reset_info_evt,
    input  wire logic        watchdog_setting_error,
    input  wire logic        wake_input_pin,
    input  wire logic        main_supply_heat_warning,
    input  wire logic        can_transceiver_overheat,
    input  wire logic        second_supply_overheat,
    input  wire logic        third_supply_undervoltage,
    input  wire logic        second_supply_undervoltage,
    input  wire logic        third_supply_overcurrent,
    input  wire logic        can_bus_failure,
    input  wire logic [1:0]  can_fault_code,
    input  wire logic [1:0]  lin_fault_code,
    output wire logic        int_n,
    output wire logic [15:0] reply_word,
    output wire logic        reply_valid
);
    // ---------------------------------------------------------------
    // Synchronisers for analog and pin levels
    // ---------------------------------------------------------------
    level_sync_if #(.W(sbc_irq_pkg::SYNC_W)) sy ();

    assign sy.raw = {lin_fault_code, can_fault_code, can_bus_failure,
                     third_supply_overcurrent, second_supply_undervoltage,
                     third_supply_undervoltage, second_supply_overheat,
                     can_transceiver_overheat, main_supply_heat_warning,
                     wake_input_pin};

    level_sync #(.W(sbc_irq_pkg::SYNC_W)) u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .lvl     (sy)
    );

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [15:0] wk_en_reg,   wk_en_next;
    logic [15:0] fl_en_reg,   fl_en_next;
    logic [15:0] lk_en_reg,   lk_en_next;
    logic [15:0] wk_st_reg,   wk_st_next;
    logic [15:0] fl_st_reg,   fl_st_next;
    logic [15:0] lk_st_reg,   lk_st_next;
    logic [15:0] wk_pend_reg, wk_pend_next;
    logic [15:0] fl_pend_reg, fl_pend_next;
    logic [15:0] lk_pend_reg, lk_pend_next;
    logic [sbc_irq_pkg::SYNC_W-1:0] prev_reg, prev_next;
    logic        int_n_reg,   int_n_next;
    logic [15:0] reply_reg,   reply_next;
    logic        valid_reg,   valid_next;

    // Combinational helpers
    logic [2:0]  ms;
    logic [2:0]  cs;
    logic        corrupt;
    logic        frame_ok;
    logic        wr;
    logic        clr_wk;
    logic        clr_fl;
    logic        clr_lk;
    logic [sbc_irq_pkg::SYNC_W-1:0] s;
    logic [sbc_irq_pkg::SYNC_W-1:0] rise;
    logic [1:0]  can_code;
    logic [1:0]  lin_code;
    logic        can_new;
    logic        lin_new;
    logic [15:0] wk_set;
    logic [15:0] fl_set;
    logic [15:0] fl_irq;
    logic [15:0] lk_set;
    logic [15:0] lk_en_eff;
    logic [15:0] wk_out;
    logic [15:0] data_out;

    always_comb begin
        s        = sy.clean;
        rise     = s & ~prev_reg;
        ms       = frame_word[sbc_irq_pkg::MS_LSB +: 3];
        cs       = frame_word[sbc_irq_pkg::CS_LSB +: 3];
        can_code = s[sbc_irq_pkg::SY_CAN_LSB +: 2];
        lin_code = s[sbc_irq_pkg::SY_LIN_LSB +: 2];

        // Bad frame check
        // frame corruption detect
        corrupt  = frame_done & (frame_len_error | (ms == sbc_irq_pkg::MS_INVALID) | mode_refused);
        frame_ok = frame_done & ~corrupt;
        wr       = frame_ok & (ms != sbc_irq_pkg::MS_READ_ONLY);
        clr_wk   = frame_ok & (cs == sbc_irq_pkg::CS_WAKE);
        clr_fl   = frame_ok & (cs == sbc_irq_pkg::CS_FAIL);
        clr_lk   = frame_ok & (cs == sbc_irq_pkg::CS_LINK);

        // ---------------------------------------------------------------
        // Event vectors aligned to register bits
        // ---------------------------------------------------------------
        wk_set = 16'h0000;
        wk_set[sbc_irq_pkg::CAN_WAKE_FLAG_BIT]      = can_wake_evt;
        wk_set[sbc_irq_pkg::WK_LIN_BIT]      = lin_wake_evt;
        wk_set[sbc_irq_pkg::WK_RISE_BIT]     = rise[sbc_irq_pkg::SY_PIN];
        wk_set[sbc_irq_pkg::WK_FALL_BIT]     = ~s[sbc_irq_pkg::SY_PIN] & prev_reg[sbc_irq_pkg::SY_PIN];
        wk_set[sbc_irq_pkg::WK_PERIODIC_BIT] = periodic_wake_evt;

        // Failure status follows the level so a lasting fault stays visible after a read,
        // but only an edge of the level raises the pin, otherwise it could never be released.
        fl_set = 16'h0000;
        fl_irq = 16'h0000;
        fl_set[sbc_irq_pkg::FL_HEAT_BIT]  = s[sbc_irq_pkg::SY_HEAT];
        fl_irq[sbc_irq_pkg::FL_HEAT_BIT]  = rise[sbc_irq_pkg::SY_HEAT];
        fl_set[sbc_irq_pkg::FL_CANOT_BIT] = s[sbc_irq_pkg::SY_CANOT];
        fl_irq[sbc_irq_pkg::FL_CANOT_BIT] = rise[sbc_irq_pkg::SY_CANOT];
        fl_set[sbc_irq_pkg::FL_OT2_BIT]   = s[sbc_irq_pkg::SY_OT2];
        fl_irq[sbc_irq_pkg::FL_OT2_BIT]   = rise[sbc_irq_pkg::SY_OT2];
        fl_set[sbc_irq_pkg::FL_UV3_BIT]   = s[sbc_irq_pkg::SY_UV3];
        fl_irq[sbc_irq_pkg::FL_UV3_BIT]   = s[sbc_irq_pkg::SY_UV3] ^ prev_reg[sbc_irq_pkg::SY_UV3];
        fl_set[sbc_irq_pkg::FL_SPI_BIT]   = corrupt;
        fl_irq[sbc_irq_pkg::FL_SPI_BIT]   = corrupt;
        fl_set[sbc_irq_pkg::FL_RST_BIT]   = reset_info_evt & sw_dev_mode;
        fl_irq[sbc_irq_pkg::FL_RST_BIT]   = reset_info_evt & sw_dev_mode;
        fl_set[sbc_irq_pkg::FL_WD_BIT]    = watchdog_setting_error;
        fl_irq[sbc_irq_pkg::FL_WD_BIT]    = watchdog_setting_error;
        fl_set[sbc_irq_pkg::FL_UV2_BIT]   = s[sbc_irq_pkg::SY_UV2];
        fl_irq[sbc_irq_pkg::FL_UV2_BIT]   = rise[sbc_irq_pkg::SY_UV2];
        fl_set[sbc_irq_pkg::FL_OC3_BIT]   = s[sbc_irq_pkg::SY_OC3];
        fl_irq[sbc_irq_pkg::FL_OC3_BIT]   = rise[sbc_irq_pkg::SY_OC3];

        can_new = (can_code != sbc_irq_pkg::FAULT_NONE) &&
                  (can_code != prev_reg[sbc_irq_pkg::SY_CAN_LSB +: 2]);
        lin_new = (lin_code != sbc_irq_pkg::FAULT_NONE) &&
                  (lin_code != prev_reg[sbc_irq_pkg::SY_LIN_LSB +: 2]);
        lk_set = 16'h0000;
        lk_set[sbc_irq_pkg::LK_BUS_BIT]   = s[sbc_irq_pkg::SY_BUS];

        // One enable bit covers both code bits of a transceiver
        // CAN and LIN fault enable
        lk_en_eff = lk_en_reg;
        lk_en_eff[sbc_irq_pkg::LK_CAN_LSB + 1] = lk_en_reg[sbc_irq_pkg::LK_CAN_LSB];
        lk_en_eff[sbc_irq_pkg::LK_LIN_LSB + 1] = lk_en_reg[sbc_irq_pkg::LK_LIN_LSB];

        // ---------------------------------------------------------------
        // Enables
        // ---------------------------------------------------------------
        wk_en_next = wk_en_reg;
        fl_en_next = fl_en_reg;
        lk_en_next = lk_en_reg;
        if (wr && (cs == sbc_irq_pkg::CS_WAKE)) begin
            wk_en_next = frame_word & sbc_irq_pkg::WAKE_EN_MASK;
        end
        if (wr && (cs == sbc_irq_pkg::CS_FAIL)) begin
            fl_en_next = frame_word & sbc_irq_pkg::FAIL_EN_MASK;
        end
        if (wr && (cs == sbc_irq_pkg::CS_LINK)) begin
            lk_en_next = frame_word & sbc_irq_pkg::LINK_EN_MASK;
        end

        // ---------------------------------------------------------------
        // Status and pending, a new event wins over the read clear
        // ---------------------------------------------------------------
        // clear after read
        wk_st_next   = (clr_wk ? 16'h0000 : wk_st_reg) | wk_set;
        fl_st_next   = (clr_fl ? 16'h0000 : fl_st_reg) | fl_set;
        lk_st_next   = (clr_lk ? 16'h0000 : lk_st_reg) | lk_set;
        if (can_new || (can_code != sbc_irq_pkg::FAULT_NONE)) begin
            lk_st_next[sbc_irq_pkg::LK_CAN_LSB +: 2] = can_code;
        end
        if (lin_new || (lin_code != sbc_irq_pkg::FAULT_NONE)) begin
            lk_st_next[sbc_irq_pkg::LK_LIN_LSB +: 2] = lin_code;
        end

        wk_pend_next = (clr_wk ? 16'h0000 : wk_pend_reg) | (wk_set & wk_en_reg);
        fl_pend_next = (clr_fl ? 16'h0000 : fl_pend_reg) | (fl_irq & fl_en_reg);
        lk_pend_next = clr_lk ? 16'h0000 : lk_pend_reg;
        lk_pend_next[sbc_irq_pkg::LK_BUS_BIT] = lk_pend_next[sbc_irq_pkg::LK_BUS_BIT] |
            (rise[sbc_irq_pkg::SY_BUS] & lk_en_eff[sbc_irq_pkg::LK_BUS_BIT]);
        lk_pend_next[sbc_irq_pkg::LK_CAN_LSB] = lk_pend_next[sbc_irq_pkg::LK_CAN_LSB] |
            (can_new & lk_en_eff[sbc_irq_pkg::LK_CAN_LSB]);
        lk_pend_next[sbc_irq_pkg::LK_LIN_LSB] = lk_pend_next[sbc_irq_pkg::LK_LIN_LSB] |
            (lin_new & lk_en_eff[sbc_irq_pkg::LK_LIN_LSB]);

        int_n_next = ~(|wk_pend_next | |fl_pend_next | |lk_pend_next);

        prev_next = s;

        // ---------------------------------------------------------------
        // Reply word
        // ---------------------------------------------------------------
        wk_out = wk_st_reg;
        wk_out[sbc_irq_pkg::WK_SUMMARY_BIT] = |fl_st_reg | |lk_st_reg;
        case (cs)
            sbc_irq_pkg::CS_WAKE: begin
                data_out = wk_out;
            end
            sbc_irq_pkg::CS_FAIL: begin
                data_out = fl_st_reg;
            end
            sbc_irq_pkg::CS_LINK: begin
                data_out = lk_st_reg;
            end
            default: begin
                data_out = 16'h0000;
            end
        endcase
        data_out[sbc_irq_pkg::CS_LSB +: 3] = cs;
        data_out[sbc_irq_pkg::MS_LSB +: 3] = 3'h0;

        // A bad frame repeats the former reply
        reply_next = frame_ok ? data_out : reply_reg;
        valid_next = frame_done;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wk_en_reg   <= sbc_irq_pkg::WAKE_EN_RST;
            fl_en_reg   <= sbc_irq_pkg::FAIL_EN_RST;
            lk_en_reg   <= sbc_irq_pkg::LINK_EN_RST;
            wk_st_reg   <= sbc_irq_pkg::STATUS_RST;
            fl_st_reg   <= sbc_irq_pkg::STATUS_RST;
            lk_st_reg   <= sbc_irq_pkg::STATUS_RST;
            wk_pend_reg <= 16'h0000;
            fl_pend_reg <= 16'h0000;
            lk_pend_reg <= 16'h0000;
            prev_reg    <= '0;
            int_n_reg   <= 1'b1;
            reply_reg   <= 16'h0000;
            valid_reg   <= 1'b0;
        end else begin
            wk_en_reg   <= wk_en_next;
            fl_en_reg   <= fl_en_next;
            lk_en_reg   <= lk_en_next;
            wk_st_reg   <= wk_st_next;
            fl_st_reg   <= fl_st_next;
            lk_st_reg   <= lk_st_next;
            wk_pend_reg <= wk_pend_next;
            fl_pend_reg <= fl_pend_next;
            lk_pend_reg <= lk_pend_next;
            prev_reg    <= prev_next;
            int_n_reg   <= int_n_next;
            reply_reg   <= reply_next;
            valid_reg   <= valid_next;
        end
    end

    assign int_n       = int_n_reg;
    assign reply_word  = reply_reg;
    assign reply_valid = valid_reg;
endmodule

// File: bench/host_frame_model.sv
// Host side model that issues one control frame at a time
`timescale 1ns/10ps
module host_frame_model (
    input  wire logic        ref_clk,
    input  wire logic        reply_valid,
    input  wire logic [15:0] reply_word,
    output logic             frame_done,
    output logic [15:0]      frame_word,
    output logic             frame_len_error,
    output logic             mode_refused
);
    initial begin
        frame_done = 1'b0;
        frame_word = 16'h0000;
        frame_len_error = 1'b0;
        mode_refused = 1'b0;
    end

    task automatic xfer(input logic [15:0] w, input logic len_err, input logic refused,
                        output logic [15:0] rep, output logic valid);
        @(posedge ref_clk);
        #1;
        frame_done = 1'b1;
        frame_word = w;
        frame_len_error = len_err;
        mode_refused = refused;
        @(posedge ref_clk);
        #1;
        valid = reply_valid;
        rep = reply_word;
        frame_done = 1'b0;
        // Outside a frame the word is not stable, so show the inverse
        frame_word = ~w;
        frame_len_error = 1'b0;
        mode_refused = 1'b0;
    endtask
endmodule

// File: bench/sbc_irq_sva.sv
// Checker for reply and interrupt pin timing of the encoder
`timescale 1ns/10ps
module sbc_irq_sva (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        frame_done,
    input wire logic [15:0] frame_word,
    input wire logic        frame_len_error,
    input wire logic        mode_refused,
    input wire logic        int_n,
    input wire logic [15:0] reply_word,
    input wire logic        reply_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic bad;
    assign bad = frame_len_error | mode_refused | (frame_word[2:0] == sbc_irq_pkg::MS_INVALID);

    a_reset_outputs: assert property (disable iff (1'b0) !resetn |=> int_n && !reply_valid && reply_word == 16'h0000)
        else $error("outputs not at reset values");
    a_reply_follows: assert property (frame_done |=> reply_valid)
        else $error("no reply after frame");
    a_reply_cause: assert property (reply_valid |-> $past(frame_done))
        else $error("reply without frame");
    a_bad_frame_hold: assert property (frame_done && bad |=> reply_word == $past(reply_word))
        else $error("bad frame changed reply");
    a_select_echo: assert property (frame_done && !bad |=>
        reply_word[5:3] == $past(frame_word[5:3]) && reply_word[2:0] == 3'h0)
        else $error("select not echoed");
    a_reserved_empty: assert property (frame_done && !bad && frame_word[5:3] > sbc_irq_pkg::CS_LINK
        |=> reply_word[15:6] == 10'h000)
        else $error("reserved select gave data");
    a_pin_release: assert property ($rose(int_n) && $past(resetn) |-> $past(frame_done))
        else $error("pin released without frame");
    a_reply_stands: assert property (!frame_done |=> $stable(reply_word))
        else $error("reply changed without frame");
endmodule

bind sbc_interrupt_event_encoder sbc_irq_sva chk (
    .ref_clk         (ref_clk),
    .resetn          (resetn),
    .frame_done      (frame_done),
    .frame_word      (frame_word),
    .frame_len_error (frame_len_error),
    .mode_refused    (mode_refused),
    .int_n           (int_n),
    .reply_word      (reply_word),
    .reply_valid     (reply_valid)
);

// File: bench/test_sbc_interrupt_event_encoder.sv
// Self-checking bench for the interrupt event encoder
`timescale 1ns/10ps
module test_sbc_interrupt_event_encoder;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        sw_dev_mode = 1'b0;
    logic [4:0]  evt = 5'h00;
    logic [7:0]  lvl = 8'h00;
    logic [1:0]  can_code = 2'h0;
    logic [1:0]  lin_code = 2'h0;
    logic        frame_done;
    logic        frame_len_error;
    logic        mode_refused;
    logic [15:0] frame_word;
    wire logic   int_n;
    wire logic   reply_valid;
    wire logic [15:0] reply_word;
    logic [15:0] got;
    logic [15:0] prev;
    logic        ok;
    int          failures = 0;
    int          checks = 0;
    int          cycles = 0;
    localparam int WBIT [3] = '{sbc_irq_pkg::CAN_WAKE_FLAG_BIT, sbc_irq_pkg::WK_LIN_BIT, sbc_irq_pkg::WK_PERIODIC_BIT};
    localparam int FBIT [7] = '{0, sbc_irq_pkg::FL_HEAT_BIT, sbc_irq_pkg::FL_CANOT_BIT, sbc_irq_pkg::FL_OT2_BIT,
                                sbc_irq_pkg::FL_UV3_BIT, sbc_irq_pkg::FL_UV2_BIT, sbc_irq_pkg::FL_OC3_BIT};

    always #2.5 ref_clk = ~ref_clk;

    sbc_interrupt_event_encoder dut (.ref_clk(ref_clk), .resetn(resetn), .frame_done(frame_done),
        .frame_word(frame_word), .frame_len_error(frame_len_error), .mode_refused(mode_refused),
        .sw_dev_mode(sw_dev_mode), .can_wake_evt(evt[0]), .lin_wake_evt(evt[1]), .periodic_wake_evt(evt[2]),
        .reset_info_evt(evt[3]), .watchdog_setting_error(evt[4]), .wake_input_pin(lvl[0]),
        .main_supply_heat_warning(lvl[1]), .can_transceiver_overheat(lvl[2]), .second_supply_overheat(lvl[3]),
        .third_supply_undervoltage(lvl[4]), .second_supply_undervoltage(lvl[5]),
        .third_supply_overcurrent(lvl[6]), .can_bus_failure(lvl[7]), .can_fault_code(can_code),
        .lin_fault_code(lin_code), .int_n(int_n), .reply_word(reply_word), .reply_valid(reply_valid));

    host_frame_model host (.ref_clk(ref_clk), .reply_valid(reply_valid), .reply_word(reply_word),
        .frame_done(frame_done), .frame_word(frame_word), .frame_len_error(frame_len_error),
        .mode_refused(mode_refused));

    // ---------------------------------------------------------------
    // Access and compare tasks
    // ---------------------------------------------------------------
    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic seen);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic frame(input logic [15:0] w, input logic len_err, input logic refused);
        host.xfer(w, len_err, refused, got, ok);
        chk1("reply_valid", 1'b1, ok);
    endtask

    task automatic rd(input logic [2:0] cs, input logic [15:0] exp);
        frame({10'h000, cs, sbc_irq_pkg::MS_READ_ONLY}, 1'b0, 1'b0);
        chk16("reply_word", exp | {10'h000, cs, 3'h0}, got);
    endtask

    task automatic wr(input logic [2:0] cs, input logic [9:0] data);
        frame({data, cs, 3'h3}, 1'b0, 1'b0);
    endtask

    task automatic pulse(input int i);
        evt[i] = 1'b1;
        @(posedge ref_clk);
        #1;
        evt[i] = 1'b0;
    endtask

    // Synchroniser plus status stage, with margin
    task automatic settle;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask

    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        chk1("int_n", 1'b1, int_n);
        rd(sbc_irq_pkg::CS_FAIL, 16'h0000);
        rd(sbc_irq_pkg::CS_LINK, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            settle();
            // Periodic wake has no enable and never drives the pin
            chk1("int_n", i == 2, int_n);
            rd(sbc_irq_pkg::CS_WAKE, 16'h0001 << WBIT[i]);
            chk1("int_n", 1'b1, int_n);
            rd(sbc_irq_pkg::CS_WAKE, 16'h0000);
        end
        // CAN wake muted, pin on rising edge only
        wr(sbc_irq_pkg::CS_WAKE, 10'h00a);
        pulse(0);
        settle();
        chk1("int_n", 1'b1, int_n);
        rd(sbc_irq_pkg::CS_WAKE, 16'h0001 << sbc_irq_pkg::CAN_WAKE_FLAG_BIT);
        lvl[0] = 1'b1;
        settle();
        chk1("int_n", 1'b0, int_n);
        rd(sbc_irq_pkg::CS_WAKE, 16'h0001 << sbc_irq_pkg::WK_RISE_BIT);
        lvl[0] = 1'b0;
        settle();
        chk1("int_n", 1'b1, int_n);
        rd(sbc_irq_pkg::CS_WAKE, 16'h0001 << sbc_irq_pkg::WK_FALL_BIT);
        wr(sbc_irq_pkg::CS_WAKE, 10'h00f);
        for (int i = 1; i < 7; i++) begin
            lvl[i] = 1'b1;
            settle();
            chk1("int_n", 1'b0, int_n);
            rd(sbc_irq_pkg::CS_WAKE, 16'h0001 << sbc_irq_pkg::WK_SUMMARY_BIT);
            rd(sbc_irq_pkg::CS_FAIL, 16'h0001 << FBIT[i]);
            lvl[i] = 1'b0;
            settle();
            if (i == 4)
                chk1("int_n", 1'b0, int_n);
            frame({10'h000, sbc_irq_pkg::CS_FAIL, sbc_irq_pkg::MS_READ_ONLY}, 1'b0, 1'b0);
            chk1("int_n", 1'b1, int_n);
        end
        pulse(4);
        settle();
        rd(sbc_irq_pkg::CS_FAIL, 16'h0001 << sbc_irq_pkg::FL_WD_BIT);
        for (int j = 0; j < 2; j++) begin
            sw_dev_mode = j[0];
            pulse(3);
            settle();
            rd(sbc_irq_pkg::CS_FAIL, j[0] ? 16'h0001 << sbc_irq_pkg::FL_RST_BIT : 16'h0000);
        end
        for (int c = 1; c < 4; c++) begin
            can_code = c[1:0];
            settle();
            chk1("int_n", 1'b0, int_n);
            rd(sbc_irq_pkg::CS_LINK, {14'h0000, c[1:0]} << sbc_irq_pkg::LK_CAN_LSB);
            can_code = 2'h0;
            lin_code = c[1:0];
            settle();
            // A code re-latched at the read stays until the next read
            rd(sbc_irq_pkg::CS_LINK, ({14'h0000, c[1:0]} << sbc_irq_pkg::LK_LIN_LSB) |
                ({14'h0000, c[1:0]} << sbc_irq_pkg::LK_CAN_LSB));
            lin_code = 2'h0;
            settle();
            rd(sbc_irq_pkg::CS_LINK, {14'h0000, c[1:0]} << sbc_irq_pkg::LK_LIN_LSB);
            rd(sbc_irq_pkg::CS_LINK, 16'h0000);
        end
        lvl[7] = 1'b1;
        settle();
        rd(sbc_irq_pkg::CS_LINK, 16'h0001 << sbc_irq_pkg::LK_BUS_BIT);
        lvl[7] = 1'b0;
        settle();
        rd(sbc_irq_pkg::CS_LINK, 16'h0001 << sbc_irq_pkg::LK_BUS_BIT);
        rd(sbc_irq_pkg::CS_LINK, 16'h0000);
        rd(3'h3, 16'h0000);
        // Length error, invalid mode, refused mode
        for (int k = 0; k < 3; k++) begin
            prev = got;
            frame({10'h000, sbc_irq_pkg::CS_WAKE, k == 1 ? 3'h0 : 3'h3}, k == 0, k == 2);
            chk16("held reply", prev, got);
            chk1("int_n", 1'b0, int_n);
            rd(sbc_irq_pkg::CS_FAIL, 16'h0001 << sbc_irq_pkg::FL_SPI_BIT);
        end
        wr(sbc_irq_pkg::CS_FAIL, 10'h000);
        frame(16'h0003, 1'b1, 1'b0);
        chk1("int_n", 1'b1, int_n);
        rd(sbc_irq_pkg::CS_FAIL, 16'h0001 << sbc_irq_pkg::FL_SPI_BIT);
        give_verdict();
    end
endmodule
